//--- design/bl_seq_regs.vh
// timing constants and codes shared by the backlight start-up and protection sequencer
`ifndef BL_SEQ_REGS_VH
`define BL_SEQ_REGS_VH

// clock figures
`define CLK_HZ              40000000
`define SW_FREQ_HZ          1200000
// switching period in clocks, rounded down (33 clocks, about 1.21 MHz)
`define SW_PERIOD_CLKS      (`CLK_HZ / `SW_FREQ_HZ)

// times in microseconds, as printed
`define EN_SD_US            2500
`define PWM_SD_US           20000
`define SEL_WIN_US          1000
`define SEL_DELAY_US        100
`define SEL_DET_US          260
`define REDUCED_LIMIT_US    5000
// time to let the internal regulator settle before sequencing on
`define LDO_SETTLE_US       10

// least times round up to whole clocks
`define US_TO_CLKS_UP(us)   ((((us) * (`CLK_HZ / 1000)) + 999) / 1000)

// sequencer states
`define ST_OFF              3'h0
`define ST_LDO              3'h1
`define ST_SELECT           3'h2
`define ST_DETECT           3'h3
`define ST_RUN              3'h4
`define ST_LATCHED          3'h5

// dimming interface codes
`define IF_PWM              1'b0
`define IF_ONE_WIRE         1'b1

`endif

//--- design/low_timeout.v
// counts how long a pin has been low and flags when a limit is passed
`include "bl_seq_regs.vh"

module low_timeout #(
  parameter LIMIT = 100000,
  parameter W     = 20
) (
  // clock and reset
  input  wire         clk_in,
  input  wire         srst_in,
  // pin level
  input  wire         pin_in,
  // stayed low past the limit
  output reg          expired_out
);

  reg [W-1:0] cnt_q;

  // restart from zero whenever the pin goes high again
  always @(posedge clk_in) begin
    if (srst_in || pin_in) begin
      cnt_q       <= {W{1'b0}};
      expired_out <= 1'b0;
    end else if (cnt_q != LIMIT[W-1:0]) begin
      cnt_q       <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      expired_out <= 1'b0;
    end else begin
      expired_out <= 1'b1;
    end
  end

endmodule

//--- design/bl_start_seq.v
// start-up, interface selection and protection sequencer of a dual-string backlight driver
//
// Contract
// - start only with supply good, enable, dimming high
// - power internal regulator before further start steps
// - selection window picks one-wire or pulse-width dimming
// - at window end, grounded sink channels disabled
// - both sinks grounded: abort, never switch
// - after detection, soft start ramps and switching begins
// - reduced current limit first 5 ms, then normal
// - enable low 2.5 ms or dimming low 20 ms shuts down
// - switching cycle fixed at 1.2 MHz, protection time base (33 clocks here, about 1.21 MHz)
// - undervoltage holds shutdown, restart after hysteresis
// - check both overvoltage comparators every switching cycle
// - switch-node overvoltage latches off until toggle or reset
// - overcurrent ends switch pulse until next cycle
// - thermal shutdown above limit, automatic resume
`include "bl_seq_regs.vh"

module bl_start_seq #(
  parameter EN_SD_CLKS   = `US_TO_CLKS_UP(`EN_SD_US),
  parameter PWM_SD_CLKS  = `US_TO_CLKS_UP(`PWM_SD_US),
  parameter WIN_CLKS     = `US_TO_CLKS_UP(`SEL_WIN_US),
  parameter DELAY_CLKS   = `US_TO_CLKS_UP(`SEL_DELAY_US),
  parameter DET_CLKS     = `US_TO_CLKS_UP(`SEL_DET_US),
  parameter LIMIT_CLKS   = `US_TO_CLKS_UP(`REDUCED_LIMIT_US),
  parameter LDO_CLKS     = `US_TO_CLKS_UP(`LDO_SETTLE_US),
  parameter MAX_DUTY     = 31
) (
  // clock and reset
  input  wire         clk_in,
  input  wire         srst_in,
  // host control pins
  input  wire         enable_in,
  input  wire         dimming_in,
  // analog monitors, already digital levels
  input  wire         supply_good_in,
  input  wire         thermal_hot_in,
  input  wire         switch_overvoltage_in,
  input  wire         sink_overvoltage_in,
  input  wire         current_limit_hit_in,
  input  wire [1:0]   current_sink_feedback_gnd_in,
  // control outputs
  output reg          ldo_on_out,
  output reg          one_wire_sel_out,
  output reg  [1:0]   channel_en_out,
  output reg          soft_start_out,
  output reg          startup_current_limit_out,
  output reg          switch_on_out,
  output reg          latched_off_out,
  output reg          shutdown_out
);

  localparam CW      = 24;
  // last clock of one switching period
  localparam SW_LAST = `SW_PERIOD_CLKS - 1;

  //////////////////////////////////////////////////////////////////////////
  // shutdown timers on the two host pins
  wire en_expired;
  wire dim_expired;

  low_timeout #(.LIMIT(EN_SD_CLKS), .W(CW)) u_en_to (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .pin_in      (enable_in),
    .expired_out (en_expired)
  );

  low_timeout #(.LIMIT(PWM_SD_CLKS), .W(CW)) u_dim_to (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .pin_in      (dimming_in),
    .expired_out (dim_expired)
  );

  //////////////////////////////////////////////////////////////////////////
  // state
  reg [2:0]    state_q;
  reg [CW-1:0] tmr_q;
  reg [CW-1:0] low_q;
  reg          seen_low_q;
  reg          one_wire_q;
  reg [1:0]    chan_q;
  reg          en_d1_q;
  reg          dim_d1_q;
  reg [5:0]    cyc_q;
  reg          pulse_q;

  // toggle on either pin clears the overvoltage latch
  wire toggle = (enable_in & ~en_d1_q) | (dimming_in & ~dim_d1_q);
  // conditions that force an orderly shutdown from the regulator, detect and run states
  wire force_off = ~supply_good_in | thermal_hot_in | en_expired | dim_expired;
  wire start_ok  = supply_good_in & enable_in & dimming_in & ~thermal_hot_in;
  wire cyc_end   = (cyc_q == SW_LAST[5:0]);

  function [CW-1:0] inc;
    input [CW-1:0] v;
    begin
      inc = v + {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  always @(posedge clk_in) begin
    if (srst_in) begin
      state_q    <= `ST_OFF;
      tmr_q      <= {CW{1'b0}};
      low_q      <= {CW{1'b0}};
      seen_low_q <= 1'b0;
      one_wire_q <= `IF_PWM;
      chan_q     <= 2'h0;
      en_d1_q    <= 1'b0;
      dim_d1_q   <= 1'b0;
    end else begin
      en_d1_q  <= enable_in;
      dim_d1_q <= dimming_in;
      case (state_q)
        `ST_OFF: begin
          tmr_q      <= {CW{1'b0}};
          one_wire_q <= `IF_PWM;
          chan_q     <= 2'h0;
          if (start_ok) begin
            state_q <= `ST_LDO;
          end
        end
        `ST_LDO: begin
          // regulator settles before the window opens
          tmr_q <= inc(tmr_q);
          if (force_off) begin
            state_q <= `ST_OFF;
          end else if (tmr_q == LDO_CLKS[CW-1:0]) begin
            state_q    <= `ST_SELECT;
            tmr_q      <= {CW{1'b0}};
            low_q      <= {CW{1'b0}};
            seen_low_q <= 1'b0;
          end
        end
        `ST_SELECT: begin
          tmr_q <= inc(tmr_q);
          // low stretch counts only the clocks from the detection delay onward
          if (enable_in) begin
            low_q <= {CW{1'b0}};
          end else if (tmr_q >= DELAY_CLKS[CW-1:0] || low_q != {CW{1'b0}}) begin
            low_q <= inc(low_q);
          end
          if (low_q > DET_CLKS[CW-1:0] && enable_in && tmr_q < WIN_CLKS[CW-1:0]) begin
            seen_low_q <= 1'b1;
          end
          if (~supply_good_in | thermal_hot_in | dim_expired) begin
            state_q <= `ST_OFF;
          end else if (tmr_q == WIN_CLKS[CW-1:0]) begin
            // enable held low by the host during the window is not a shutdown
            one_wire_q <= seen_low_q ? `IF_ONE_WIRE : `IF_PWM;
            state_q    <= `ST_DETECT;
          end
        end
        `ST_DETECT: begin
          chan_q <= ~current_sink_feedback_gnd_in;
          if (force_off) begin
            state_q <= `ST_OFF;
          end else if (&current_sink_feedback_gnd_in) begin
            state_q <= `ST_OFF;
          end else begin
            state_q <= `ST_RUN;
            tmr_q   <= {CW{1'b0}};
          end
        end
        `ST_RUN: begin
          if (tmr_q != LIMIT_CLKS[CW-1:0]) begin
            tmr_q <= inc(tmr_q);
          end
          if (switch_overvoltage_in && cyc_end) begin
            state_q <= `ST_LATCHED;
          end else if (force_off) begin
            state_q <= `ST_OFF;
          end
        end
        `ST_LATCHED: begin
          // only a pin toggle or power-on reset clears this
          if (toggle) begin
            state_q <= `ST_OFF;
          end
        end
        default: begin
          state_q <= `ST_OFF;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // switching cycle and pulse-by-pulse limit
  always @(posedge clk_in) begin
    if (srst_in || state_q != `ST_RUN) begin
      cyc_q   <= 6'h00;
      pulse_q <= 1'b0;
    end else begin
      cyc_q <= cyc_end ? 6'h00 : cyc_q + 6'h01;
      if (cyc_end) begin
        pulse_q <= 1'b1;
      end else if (current_limit_hit_in || cyc_q >= MAX_DUTY[5:0]) begin
        pulse_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge clk_in) begin
    if (srst_in) begin
      ldo_on_out                <= 1'b0;
      one_wire_sel_out          <= 1'b0;
      channel_en_out            <= 2'h0;
      soft_start_out            <= 1'b0;
      startup_current_limit_out <= 1'b1;
      switch_on_out             <= 1'b0;
      latched_off_out           <= 1'b0;
      shutdown_out              <= 1'b1;
    end else begin
      ldo_on_out                <= (state_q != `ST_OFF) && (state_q != `ST_LATCHED);
      one_wire_sel_out          <= one_wire_q;
      channel_en_out            <= (state_q == `ST_RUN) ? chan_q : 2'h0;
      soft_start_out            <= (state_q == `ST_RUN);
      startup_current_limit_out <= (tmr_q != LIMIT_CLKS[CW-1:0]) || (state_q != `ST_RUN);
      // overvoltage on either node or overcurrent drops the switch on the next clock
      switch_on_out             <= pulse_q && (state_q == `ST_RUN) && !current_limit_hit_in
                                   && !switch_overvoltage_in && !sink_overvoltage_in;
      latched_off_out           <= (state_q == `ST_LATCHED);
      shutdown_out              <= (state_q == `ST_OFF) || (state_q == `ST_LATCHED);
    end
  end

endmodule

//--- verif/host_pins.sv
// host gpio model driving the enable and dimming pins
module host_pins (
  // clock
  input  logic clk_in,
  // pins
  output logic enable_out,
  output logic dimming_out
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////
  // pins start low, as the pull-downs leave them
  initial begin
    enable_out = 1'b0;
    dimming_out = 1'b0;
  end
  // caller sits at a falling edge, so levels never move at sampling
  task automatic drive(input logic en, input logic dim);
    enable_out = en;
    dimming_out = dim;
  endtask
  // dimming stays high while enable carries the selection pattern
  task automatic select_one_wire(input int dly, input int det);
    drive(1'b1, 1'b1);
    repeat (dly) @(negedge clk_in);
    enable_out = 1'b0;
    repeat (det) @(negedge clk_in);
    enable_out = 1'b1;
  endtask
endmodule

//--- verif/bl_start_seq_chk.sv
// assertion checker watching the backlight sequencer ports
module bl_start_seq_chk #(
  parameter EN_SD_CLKS  = 20,
  parameter PWM_SD_CLKS = 40,
  parameter LIMIT_CLKS  = 50
) (
  // clock, reset, inputs and the channel enable outputs
  input logic       clk_in, srst_in, enable_in, dimming_in, supply_good_in,
  input logic       thermal_hot_in, switch_overvoltage_in, sink_overvoltage_in,
  input logic       current_limit_hit_in,
  input logic [1:0] current_sink_feedback_gnd_in, channel_en_out,
  // outputs
  input logic       ldo_on_out, one_wire_sel_out, soft_start_out,
  input logic       startup_current_limit_out, switch_on_out, latched_off_out, shutdown_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int en_lo, dim_lo, run_n;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////
  // low and run times; counters avoid long repetitions
  always @(posedge clk_in) begin
    en_lo <= (srst_in | enable_in) ? 0 : en_lo + 1;
    dim_lo <= (srst_in | dimming_in) ? 0 : dim_lo + 1;
    run_n <= soft_start_out ? run_n + 1 : 0;
  end
  a_start_gate:
    assert property ($rose(ldo_on_out) |-> $past(supply_good_in & enable_in & dimming_in, 2))
    else $error("regulator on without start conditions");
  a_gate_needs:
    assert property (switch_on_out |-> ldo_on_out && soft_start_out && channel_en_out != 2'b00)
    else $error("gate on outside a run");
  a_chan_ground:
    assert property (soft_start_out |-> (channel_en_out & current_sink_feedback_gnd_in) == 2'b00)
    else $error("grounded channel in loop");
  a_limit_early:
    assert property (soft_start_out && run_n < LIMIT_CLKS - 2 |-> startup_current_limit_out)
    else $error("normal limit too early");
  a_limit_late:
    assert property (soft_start_out && run_n > LIMIT_CLKS + 3 |-> !startup_current_limit_out)
    else $error("reduced limit too long");
  a_cycle_cut:
    assert property (current_limit_hit_in |=> !switch_on_out) else $error("gate on past limit");
  a_ov_cut:
    assert property (switch_overvoltage_in || sink_overvoltage_in |=> !switch_on_out)
    else $error("gate on during overvoltage");
  a_ov_latch:
    assert property (switch_overvoltage_in && soft_start_out |-> ##[1:40] latched_off_out)
    else $error("no latch on overvoltage");
  a_latch_quiet:
    assert property (latched_off_out |-> !switch_on_out && !soft_start_out)
    else $error("running while latched");
  a_hot_off:
    assert property (thermal_hot_in |-> ##[1:3] shutdown_out) else $error("hot but running");
  a_uvlo_off:
    assert property (!supply_good_in |-> ##[1:3] shutdown_out) else $error("low supply running");
  a_en_timeout:
    assert property (en_lo > EN_SD_CLKS + 3 |-> shutdown_out) else $error("enable low kept on");
  a_dim_timeout:
    assert property (dim_lo > PWM_SD_CLKS + 3 |-> shutdown_out) else $error("dimming low kept on");
  // main scenarios reached
  c_latch: cover property ($rose(latched_off_out));
  c_one_wire: cover property ($rose(one_wire_sel_out));
  c_limit_drop: cover property ($fell(startup_current_limit_out) && soft_start_out);
  c_gate_on: cover property (switch_on_out && channel_en_out == 2'b11);
endmodule

//--- verif/tb_backlight_start_protect_seq.sv
// self-checking bench for the backlight start-up sequencer
module tb_backlight_start_protect_seq;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic srst_in, supply_good_in, thermal_hot_in, switch_overvoltage_in, sink_overvoltage_in;
  logic current_limit_hit_in, run_clr, ever_run = 1'b0;
  logic [1:0] current_sink_feedback_gnd_in;
  logic [31:0] lfsr = 32'h1297ae67;
  logic [5:0] exp_q[$];
  int bad_count = 0;
  int check_count = 0;
  event probe;
  wire enable_in, dimming_in, ldo_on_out, one_wire_sel_out, soft_start_out, switch_on_out;
  wire startup_current_limit_out, latched_off_out, shutdown_out;
  wire [1:0] channel_en_out;
  ////////////////////////////////////////
  // 40 mhz clock
  always #12.5 clk_in = ~clk_in;
  host_pins i_host (.clk_in, .enable_out(enable_in), .dimming_out(dimming_in));
  // short counts keep the run brief
  bl_start_seq #(.EN_SD_CLKS(20), .PWM_SD_CLKS(40), .WIN_CLKS(60), .DELAY_CLKS(8),
    .DET_CLKS(16), .LIMIT_CLKS(50), .LDO_CLKS(4)) i_dut (.clk_in, .srst_in, .enable_in,
    .dimming_in, .supply_good_in, .thermal_hot_in, .switch_overvoltage_in,
    .sink_overvoltage_in, .current_limit_hit_in, .current_sink_feedback_gnd_in, .ldo_on_out,
    .one_wire_sel_out, .channel_en_out, .soft_start_out, .startup_current_limit_out,
    .switch_on_out, .latched_off_out, .shutdown_out);
  // sticky flag: did a run ever begin
  always @(posedge clk_in) ever_run <= run_clr ? 1'b0 : (ever_run | soft_start_out);
  task automatic check(input logic [5:0] seen, input logic [5:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] status expected %h seen %h", want, seen);
    end
  endtask
  // run-only fields are masked while stopped, where their value is open
  always @(probe) check({latched_off_out, shutdown_out, {one_wire_sel_out, channel_en_out,
    startup_current_limit_out} & {4{soft_start_out}}}, exp_q.pop_front());
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic note(input logic [5:0] v);
    exp_q.push_back(v);
    -> probe;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // bounded wait on the run flag, then let two edges settle
  task automatic wait_ss(input logic lvl);
    int i;
    for (i = 0; i < 400 && soft_start_out !== lvl; i++) @(negedge clk_in);
    if (i == 400) begin
      check({5'h00, soft_start_out}, {5'h00, lvl});
      end_of_test();
    end
    cyc(2);
  endtask
  // next step of the bench's pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // random short dimming lows and comparator hits, all below the timeout
  task automatic jitter(input int n);
    repeat (n) begin
      lfsr = lfsr_next(lfsr);
      current_limit_hit_in = lfsr[3] & lfsr[4];
      sink_overvoltage_in = lfsr[5] & lfsr[6] & lfsr[7];
      i_host.drive(1'b1, 1'b0);
      cyc(lfsr[12:8] + 1);
      i_host.drive(1'b1, 1'b1);
      cyc(lfsr[17:13] + 1);
    end
    current_limit_hit_in = 1'b0;
    sink_overvoltage_in = 1'b0;
  endtask
  // fields: latched, shutdown, one-wire, channels, reduced limit
  initial begin
    srst_in = 1'b1;
    supply_good_in = 1'b1;
    thermal_hot_in = 1'b0;
    switch_overvoltage_in = 1'b0;
    sink_overvoltage_in = 1'b0;
    current_limit_hit_in = 1'b0;
    run_clr = 1'b0;
    // one random live channel for the first run
    lfsr = lfsr_next(lfsr);
    current_sink_feedback_gnd_in = {lfsr[0], ~lfsr[0]};
    cyc(5);
    srst_in = 1'b0;
    note(6'b010000);
    i_host.drive(1'b1, 1'b1);
    wait_ss(1'b1);
    note({3'b000, ~current_sink_feedback_gnd_in, 1'b1});
    cyc(60);
    note({3'b000, ~current_sink_feedback_gnd_in, 1'b0});
    jitter(8);
    note({3'b000, ~current_sink_feedback_gnd_in, 1'b0});
    i_host.drive(1'b0, 1'b1);
    cyc(15);
    note({3'b000, ~current_sink_feedback_gnd_in, 1'b0});
    wait_ss(1'b0);
    note(6'b010000);
    $display("test pulse-width run done");
    current_sink_feedback_gnd_in = 2'b00;
    i_host.select_one_wire(20, 20);
    wait_ss(1'b1);
    note(6'b001111);
    switch_overvoltage_in = 1'b1;
    wait_ss(1'b0);
    switch_overvoltage_in = 1'b0;
    note(6'b110000);
    i_host.drive(1'b0, 1'b1);
    cyc(2);
    i_host.drive(1'b1, 1'b1);
    wait_ss(1'b1);
    note(6'b000111);
    $display("test one-wire and latch done");
    for (int k = 0; k < 2; k++) begin
      thermal_hot_in = (k == 0);
      supply_good_in = (k == 0);
      cyc(4);
      note(6'b010000);
      thermal_hot_in = 1'b0;
      supply_good_in = 1'b1;
      wait_ss(1'b1);
      note(6'b000111);
    end
    $display("test thermal and supply done");
    i_host.drive(1'b0, 1'b1);
    wait_ss(1'b0);
    current_sink_feedback_gnd_in = 2'b11;
    run_clr = 1'b1;
    cyc(1);
    run_clr = 1'b0;
    i_host.drive(1'b1, 1'b1);
    cyc(200);
    check({5'h00, ever_run}, 6'h00);
    $display("test both sinks grounded done");
    end_of_test();
  end
endmodule
bind bl_start_seq bl_start_seq_chk #(.EN_SD_CLKS(EN_SD_CLKS), .PWM_SD_CLKS(PWM_SD_CLKS),
  .LIMIT_CLKS(LIMIT_CLKS)) i_chk (.clk_in(clk_in), .srst_in(srst_in),
  .enable_in(enable_in), .dimming_in(dimming_in), .supply_good_in(supply_good_in),
  .thermal_hot_in(thermal_hot_in), .switch_overvoltage_in(switch_overvoltage_in),
  .sink_overvoltage_in(sink_overvoltage_in), .current_limit_hit_in(current_limit_hit_in),
  .current_sink_feedback_gnd_in(current_sink_feedback_gnd_in),
  .channel_en_out(channel_en_out), .ldo_on_out(ldo_on_out),
  .one_wire_sel_out(one_wire_sel_out), .soft_start_out(soft_start_out),
  .startup_current_limit_out(startup_current_limit_out), .switch_on_out(switch_on_out),
  .latched_off_out(latched_off_out), .shutdown_out(shutdown_out));
